// File: verilog/adc_cfg_pkg.sv
`default_nettype none
package adc_cfg_pkg;
  // Register layout and reset value.
  localparam int CFG_WIDTH = 10;
  localparam int BUS_WIDTH = 12;
  localparam logic [9:0] CFG_RESET = 10'h020;
  localparam int REF_SEL_BIT = 0;
  localparam int MODE_BIT = 1;
  localparam int PD_BIT = 2;
  localparam int SEL_LSB = 3;
  localparam int SEL_MSB = 7;
  localparam int CHECK_LSB = 8;
  localparam int CHECK_MSB = 9;
  localparam int REG_SELECT_LSB = 10;
  localparam logic [1:0] SELECT_CFG = 2'h0;
  // Input selection codes on bits 7..3.
  localparam logic [4:0] INPUT_POS = 5'h00;
  localparam logic [4:0] INPUT_NEG = 5'h01;
  localparam logic [4:0] INPUT_DIFF = 5'h04;
  localparam logic [4:0] INPUT_SCAN = 5'h11;
  // Self-check sources on bits 9..8.
  localparam logic [1:0] CHECK_NONE = 2'h0;
  localparam logic [1:0] CHECK_UPPER = 2'h1;
  localparam logic [1:0] CHECK_MID = 2'h2;
  localparam logic [1:0] CHECK_LOWER = 2'h3;
  // Result buffer and one-shot timing.
  localparam int SAMPLE_WIDTH = 12;
  localparam int FIFO_DEPTH = 32;
  localparam int CLK_PERIOD_NS = 40;
  localparam int STEP_TIME_NS = 125;
  localparam int STEP_CYCLES_RAW = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_CYCLES = (STEP_CYCLES_RAW < 1) ? 1 : STEP_CYCLES_RAW;
  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_WAIT,
    CONV_STORE
  } conv_state_type;
endpackage : adc_cfg_pkg
`default_nettype wire

// File: verilog/adc_input_config_control.sv
// Operation
// (RL1) Bit 0 clear picks internal reference, set picks external reference.
// (RL2) Mode bit clear: each sample clock falling edge stores one result.
// (RL3) Mode bit set: sample clock pin becomes a one-shot start input.
// (RL4) One-shot falling edge holds all selected inputs, then converts in sequence.
// (RL5) Block ready goes active once the trigger count of results is stored.
// (RL6) Bit 2 powers down the core; bus and FIFO reads keep working.
// (RL7) Configuration resets to zero except bit 5, which resets to one.
// (RL8) Codes 00000, 00001, 00100 pick positive, negative, differential input.
// (RL9) Code 10001 autoscans both inputs, positive first, alternating.
// (RL10) Host writes only the four defined selection codes.
// (RL11) Bits 9..8 pick normal, upper, midpoint or lower reference conversion.
// (RL12) Write data bits 9..0, bits 11..10 select register, 00 is this one.
// (RL13) Autoscan order stays fixed so blocks start on the first channel.
// (RL14) Register holds until write or reset; changes apply from next conversion.
`timescale 1ns/1ps
`default_nettype none

module result_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [$clog2(DEPTH+1)-1:0] count_reg;
  logic push;
  logic pop;

  // Full and empty follow the stored count, so neither can lie.
  assign in_ready = (count_reg != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = (count_reg != '0);
  assign push = in_valid && in_ready && clk_en;
  assign pop = out_valid && out_ready && clk_en;
  assign out_data = mem[rd_ptr_reg];
  assign level = count_reg;

  // Storage array has no reset; only the pointers and the count need a defined value.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointer and count update.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : result_fifo

module adc_input_config_control #(
  parameter int FIFO_DEPTH = adc_cfg_pkg::FIFO_DEPTH,
  parameter int STEP_CYCLES = adc_cfg_pkg::STEP_CYCLES
) (
  // Clock, reset and enable.
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Parallel bus; data lines are two-way.
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [11:0] data_in,
  output logic [11:0] data_out,
  output logic data_oe_n,
  // Sample clock or one-shot start pin.
  input wire logic sample_clock_pin,
  // Digitised results from the conversion core.
  input wire logic [11:0] positive_code,
  input wire logic [11:0] negative_code,
  input wire logic [11:0] differential_code,
  input wire logic [11:0] upper_code,
  input wire logic [11:0] lower_code,
  // Trigger level from the block-size logic.
  input wire logic [5:0] trigger_level,
  // Core controls and status.
  output logic reference_external,
  output logic core_power_down,
  output logic sample_hold,
  output logic block_ready_output,
  output logic [9:0] config_value
);
  localparam int LW = $clog2(FIFO_DEPTH + 1);
  localparam int TW = $clog2(STEP_CYCLES + 1);

  logic [9:0] cfg_reg;
  logic [9:0] active_reg;
  adc_cfg_pkg::conv_state_type state_reg;
  adc_cfg_pkg::conv_state_type state_next;
  logic [TW-1:0] timer_reg;
  logic chan_reg;
  logic steps_reg;
  logic scan_next_reg;
  logic pin_prev_reg;
  logic wr_prev_reg;
  logic rd_prev_reg;
  logic [11:0] data_out_reg;
  logic [11:0] result_reg;

  logic wr_strobe;
  logic rd_strobe;
  logic cfg_write;
  logic pin_fall;
  logic start;
  logic one_shot;
  logic [4:0] sel;
  logic [1:0] check;
  logic scan;
  logic [12:0] mid_sum;
  logic [11:0] chan_code;
  logic [11:0] store_code;
  logic push_valid;
  logic push_ready;
  logic pop_valid;
  logic [11:0] pop_data;
  logic [LW-1:0] level;
  logic [4:0] cfg_sel;
  logic [1:0] bus_select;

  // Field views of the bus word and of the live register.
  // Taking positions from the package keeps decode and checks in step.
  assign bus_select = data_in[adc_cfg_pkg::REG_SELECT_LSB+1:adc_cfg_pkg::REG_SELECT_LSB];
  assign cfg_sel = cfg_reg[adc_cfg_pkg::SEL_MSB:adc_cfg_pkg::SEL_LSB];

  // Bus strobes are taken once, on the falling edge of the qualified line.
  // Holding a strobe low therefore writes or pops once, not every cycle.
  assign wr_strobe = !cs_n && !wr_n && wr_prev_reg;
  assign rd_strobe = !cs_n && !rd_n && rd_prev_reg;
  assign cfg_write = wr_strobe && (bus_select == adc_cfg_pkg::SELECT_CFG); // RL12

  // Start edge; a powered-down core ignores it while the bus stays alive.
  assign pin_fall = pin_prev_reg && !sample_clock_pin;
  assign start = pin_fall && !cfg_reg[adc_cfg_pkg::PD_BIT]; // RL6

  // Decoding works from the snapshot taken at the start of a conversion.
  assign one_shot = active_reg[adc_cfg_pkg::MODE_BIT];
  assign sel = active_reg[adc_cfg_pkg::SEL_MSB:adc_cfg_pkg::SEL_LSB];
  assign check = active_reg[adc_cfg_pkg::CHECK_MSB:adc_cfg_pkg::CHECK_LSB];
  assign scan = (sel == adc_cfg_pkg::INPUT_SCAN);
  assign mid_sum = {1'b0, upper_code} + {1'b0, lower_code};

  // Channel choice; reserved codes fall back to the positive input.
  assign chan_code = (sel == adc_cfg_pkg::INPUT_NEG) ? negative_code : // RL8
                     (sel == adc_cfg_pkg::INPUT_DIFF) ? differential_code : // RL8
                     (scan && chan_reg) ? negative_code : positive_code; // RL9

  // Self-check sources replace the channel result.
  assign store_code = (check == adc_cfg_pkg::CHECK_UPPER) ? upper_code : // RL11
                      (check == adc_cfg_pkg::CHECK_MID) ? mid_sum[12:1] : // RL11
                      (check == adc_cfg_pkg::CHECK_LOWER) ? lower_code : result_reg; // RL11

  assign push_valid = (state_reg == adc_cfg_pkg::CONV_STORE);

  // Level-type ready: stays active while a full block waits unread.
  assign block_ready_output = (trigger_level != '0) &&
                              ({{(7 - LW){1'b0}}, level} >= {1'b0, trigger_level}); // RL5

  assign reference_external = cfg_reg[adc_cfg_pkg::REF_SEL_BIT]; // RL1
  assign core_power_down = cfg_reg[adc_cfg_pkg::PD_BIT]; // RL6
  assign config_value = cfg_reg;
  assign data_out = data_out_reg;
  assign data_oe_n = !(!cs_n && !rd_n);
  assign sample_hold = (state_reg != adc_cfg_pkg::CONV_IDLE); // RL4

  // Conversion sequencer; a full FIFO stalls it in the store state.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      adc_cfg_pkg::CONV_IDLE: begin
        if (start) begin
          state_next = adc_cfg_pkg::CONV_WAIT;
        end
      end
      adc_cfg_pkg::CONV_WAIT: begin
        if (timer_reg <= TW'(1)) begin
          state_next = adc_cfg_pkg::CONV_STORE;
        end
      end
      adc_cfg_pkg::CONV_STORE: begin
        if (push_ready) begin
          state_next = steps_reg ? adc_cfg_pkg::CONV_WAIT : adc_cfg_pkg::CONV_IDLE;
        end
      end
      default: begin
        state_next = adc_cfg_pkg::CONV_IDLE;
      end
    endcase
  end

  // Configuration register and bus edge history.
  // A low enable holds the edge history too, so a strobe that comes and goes
  // while frozen is lost rather than delayed; hosts must not rely on it.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg <= adc_cfg_pkg::CFG_RESET; // RL7
      wr_prev_reg <= 1'b1;
      rd_prev_reg <= 1'b1;
      pin_prev_reg <= 1'b1;
      data_out_reg <= '0;
    end else if (clk_en) begin
      wr_prev_reg <= cs_n || wr_n;
      rd_prev_reg <= cs_n || rd_n;
      pin_prev_reg <= sample_clock_pin;
      if (cfg_write) begin
        cfg_reg <= data_in[adc_cfg_pkg::CFG_WIDTH-1:0]; // RL14
      end
      if (rd_strobe) begin
        data_out_reg <= pop_valid ? pop_data : '0; // RL6
      end
    end
  end

  // Sequencer state. The snapshot means a write mid-sequence only takes
  // effect on the next start, which keeps autoscan pairs aligned.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= adc_cfg_pkg::CONV_IDLE;
      active_reg <= adc_cfg_pkg::CFG_RESET;
      timer_reg <= '0;
      chan_reg <= 1'b0;
      steps_reg <= 1'b0;
      scan_next_reg <= 1'b0;
      result_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
      if (cfg_write) begin
        scan_next_reg <= 1'b0; // RL13
      end
      if (state_reg == adc_cfg_pkg::CONV_IDLE && start) begin
        active_reg <= cfg_reg; // RL14
        if (cfg_reg[adc_cfg_pkg::MODE_BIT]) begin
          timer_reg <= TW'(STEP_CYCLES); // RL3
          chan_reg <= 1'b0; // RL4
          steps_reg <= (cfg_sel == adc_cfg_pkg::INPUT_SCAN); // RL4
        end else begin
          timer_reg <= TW'(1); // RL2
          chan_reg <= scan_next_reg && !cfg_write; // RL9
          steps_reg <= 1'b0; // RL2
        end
      end else if (state_reg == adc_cfg_pkg::CONV_WAIT) begin
        timer_reg <= timer_reg - 1'b1;
        result_reg <= chan_code;
      end else if (state_reg == adc_cfg_pkg::CONV_STORE && push_ready) begin
        if (scan && !one_shot && !cfg_write) begin
          scan_next_reg <= !chan_reg; // RL9
        end
        if (steps_reg) begin
          chan_reg <= 1'b1; // RL9
          steps_reg <= 1'b0;
          timer_reg <= TW'(STEP_CYCLES);
        end
      end
    end
  end

  // Result buffer between conversion and bus reads.
  result_fifo #(
    .WIDTH(adc_cfg_pkg::SAMPLE_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(store_code),
    .out_valid(pop_valid),
    .out_ready(rd_strobe),
    .out_data(pop_data),
    .level(level)
  );
endmodule : adc_input_config_control
`default_nettype wire

// File: dv/adc_cfg_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the register bus, the conversion start and the block flag.
module adc_cfg_checker (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Bus side.
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [11:0] data_in,
  input wire logic data_oe_n,
  // Conversion side.
  input wire logic sample_clock_pin,
  input wire logic [5:0] trigger_level,
  input wire logic reference_external,
  input wire logic core_power_down,
  input wire logic sample_hold,
  input wire logic block_ready_output,
  input wire logic [9:0] config_value
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // A write lands once, on the first edge that sees both strobes low.
  property p_write;
    clk_en && !cs_n && !wr_n && $past(cs_n || wr_n) && data_in[11:10] == 2'h0
      |=> config_value == $past(data_in[9:0]);
  endproperty
  a_write: assert property (p_write) else $error("config write lost");
  property p_keep;
    cs_n || wr_n || data_in[11:10] != 2'h0 |=> $stable(config_value);
  endproperty
  a_keep: assert property (p_keep) else $error("config changed unasked");
  property p_ref;
    reference_external == config_value[0];
  endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong");
  property p_pd;
    core_power_down == config_value[2];
  endproperty
  a_pd: assert property (p_pd) else $error("power down wrong");
  property p_oe;
    data_oe_n == (cs_n || rd_n);
  endproperty
  a_oe: assert property (p_oe) else $error("read drive wrong");
  // A one-shot start seen while idle and powered must put the inputs into hold next cycle.
  property p_start;
    clk_en && $fell(sample_clock_pin) && config_value[1] && !core_power_down && !sample_hold
      |=> sample_hold;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_pd_idle;
    core_power_down && !sample_hold |=> !sample_hold;
  endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("converted in power down");
  property p_ready_off;
    trigger_level == 6'h00 |-> !block_ready_output;
  endproperty
  a_ready_off: assert property (p_ready_off) else $error("flag without level");
  c_write: cover property (!cs_n && !wr_n && $past(wr_n));
  c_start: cover property ($rose(sample_hold));
  c_ready: cover property ($rose(block_ready_output));
endmodule : adc_cfg_checker
bind adc_input_config_control adc_cfg_checker u_checker (
  .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
  .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .data_in(data_in), .data_oe_n(data_oe_n),
  .sample_clock_pin(sample_clock_pin), .trigger_level(trigger_level),
  .reference_external(reference_external), .core_power_down(core_power_down),
  .sample_hold(sample_hold), .block_ready_output(block_ready_output),
  .config_value(config_value)
);
`default_nettype wire

// File: dv/bus_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host on the parallel bus; it moves its lines on the falling clock edge.
module bus_host_model (
  // Bus clock.
  input wire logic sys_clk,
  // Strobes and data.
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic [11:0] data_in
);
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    data_in = 12'h000;
  end
  // Strobe low over one rising edge, then high for a full cycle between accesses.
  task automatic access(input logic wr, input logic [11:0] d);
    @(negedge sys_clk);
    cs_n = 1'b0;
    wr_n = !wr;
    rd_n = wr;
    data_in = d;
    @(negedge sys_clk);
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    data_in = ~d; // Released lines must not keep the last value.
  endtask : access
endmodule : bus_host_model
`default_nettype wire

// File: dv/adc_input_config_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_input_config_control_tb;
  logic sys_clk, resetn, clk_en, cs_n, wr_n, rd_n, data_oe_n, sample_clock_pin;
  logic reference_external, core_power_down, sample_hold, block_ready_output;
  logic taken = 1'b0;
  logic prev_hi = 1'b1;
  logic [11:0] data_in, data_out, positive_code, negative_code, differential_code;
  logic [11:0] upper_code, lower_code;
  logic [9:0] config_value, v;
  logic [5:0] trigger_level;
  logic [31:0] seed = 32'h7BCA5B9B;
  logic [11:0] exp_q[$];
  int n_mismatch = 0;
  int checks_done = 0;
  logic [4:0] sel_tab[4] = '{adc_cfg_pkg::INPUT_POS, adc_cfg_pkg::INPUT_NEG,
    adc_cfg_pkg::INPUT_DIFF, adc_cfg_pkg::INPUT_SCAN};

  adc_input_config_control #(.STEP_CYCLES(1)) u_dut (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
    .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .sample_clock_pin(sample_clock_pin),
    .positive_code(positive_code), .negative_code(negative_code),
    .differential_code(differential_code), .upper_code(upper_code), .lower_code(lower_code),
    .trigger_level(trigger_level), .reference_external(reference_external),
    .core_power_down(core_power_down), .sample_hold(sample_hold),
    .block_ready_output(block_ready_output), .config_value(config_value)
  );
  bus_host_model u_host (
    .sys_clk(sys_clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .data_in(data_in)
  );

  // Free-running 25 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  // The midpoint sum keeps its carry so the halving is exact.
  function automatic logic [11:0] expect_for(input logic [9:0] c);
    logic [12:0] s;
    s = {1'b0, upper_code} + {1'b0, lower_code};
    case (c[9:8])
      2'h1: return upper_code;
      2'h2: return s[12:1];
      2'h3: return lower_code;
      default: ;
    endcase
    if (c[7:3] == adc_cfg_pkg::INPUT_NEG) return negative_code;
    if (c[7:3] == adc_cfg_pkg::INPUT_DIFF) return differential_code;
    return positive_code;
  endfunction : expect_for

  task automatic new_codes();
    seed = xs(seed);
    positive_code = seed[11:0];
    negative_code = seed[23:12];
    seed = xs(seed);
    differential_code = seed[11:0];
    upper_code = seed[23:12];
    lower_code = seed[31:20];
  endtask : new_codes

  task automatic check(input logic ok);
    checks_done++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t: output differs from expectation", $time);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // The extra edge lets the register update land before it is looked at.
  task automatic wr(input logic [1:0] sel, input logic [9:0] val);
    u_host.access(1'b1, {sel, val});
    @(negedge sys_clk);
  endtask : wr

  task automatic rd();
    u_host.access(1'b0, 12'h000);
  endtask : rd

  task automatic pulse();
    sample_clock_pin = 1'b0;
    repeat (4) @(negedge sys_clk);
    sample_clock_pin = 1'b1;
    repeat (6) @(negedge sys_clk);
  endtask : pulse

  // Spot each read the design takes, then compare its data half a cycle later.
  always @(posedge sys_clk) begin
    taken <= !cs_n && !rd_n && prev_hi;
    prev_hi <= cs_n || rd_n;
  end
  always @(negedge sys_clk) begin
    if (taken) begin
      if (exp_q.size() == 0)
        check(1'b0);
      else
        check(data_out === exp_q.pop_front());
    end
  end

  // Cuts a hung run short.
  initial begin
    #400000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    sample_clock_pin = 1'b1;
    trigger_level = 6'h00;
    new_codes();
    repeat (8) @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    check(config_value === adc_cfg_pkg::CFG_RESET);
    check({reference_external, core_power_down, block_ready_output} === 3'h0);
    $display("test reset done");
    // Every defined selection code against every check source; low bits are random.
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      v = {i[1:0], sel_tab[i[3:2]], seed[2:0]};
      wr(2'h0, v);
      check(config_value === v);
      check({reference_external, core_power_down} === {v[0], v[2]});
      for (int k = 1; k < 4; k++) begin
        wr(k[1:0], ~v);
        check(config_value === v);
      end
    end
    $display("test register done");
    // One result per sample clock fall, for each source in turn.
    for (int j = 0; j < 6; j++) begin
      v = (j < 4) ? {j[1:0], sel_tab[0], 3'h0} : {2'h0, sel_tab[j - 3], 3'h0};
      wr(2'h0, v);
      new_codes();
      pulse();
      exp_q.push_back(expect_for(v));
    end
    repeat (6) rd();
    check(block_ready_output === 1'b0);
    $display("test continuous done");
    // Fill the buffer to its depth; the flag may rise only on the last store.
    trigger_level = 6'h20;
    wr(2'h0, {2'h0, sel_tab[0], 3'h0});
    for (int j = 0; j < 32; j++) begin
      check(block_ready_output === 1'b0);
      pulse();
      exp_q.push_back(positive_code);
    end
    check(block_ready_output === 1'b1);
    exp_q.push_back(12'h000);
    repeat (33) rd();
    $display("test fill done");
    // One start converts both inputs, positive first.
    trigger_level = 6'h02;
    wr(2'h0, {2'h0, sel_tab[3], 3'h2});
    pulse();
    exp_q.push_back(positive_code);
    exp_q.push_back(negative_code);
    check(block_ready_output === 1'b1);
    repeat (2) rd();
    check(block_ready_output === 1'b0);
    // Continuous autoscan alternates per sample clock fall, positive first.
    wr(2'h0, {2'h0, sel_tab[3], 3'h0});
    repeat (3) pulse();
    exp_q.push_back(positive_code);
    exp_q.push_back(negative_code);
    exp_q.push_back(positive_code);
    repeat (3) rd();
    // A low enable freezes all state; the empty read below proves no store.
    clk_en = 1'b0;
    u_host.access(1'b1, 12'h3FF);
    pulse();
    clk_en = 1'b1;
    @(negedge sys_clk);
    check(config_value === {2'h0, sel_tab[3], 3'h0});
    $display("test one shot done");
    // Powered down: starts are dropped, yet bus and buffer still answer.
    wr(2'h0, {2'h0, sel_tab[3], 3'h6});
    check(core_power_down === 1'b1);
    pulse();
    exp_q.push_back(12'h000);
    rd();
    repeat (2) @(negedge sys_clk);
    check(exp_q.size() == 0);
    $display("test power down done");
    print_verdict();
  end
endmodule : adc_input_config_control_tb
`default_nettype wire
